/* File: hbdp_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module hbdp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset, active high
	hbdp_fifo_if.fifo port // Push and pop streams
);
	import hbdp_pkg::*;
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic do_push;
	logic do_pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	assign port.push_ready = (count != (PW+1)'(DEPTH));
	assign port.pop_valid = (count != '0);
	assign port.pop_data = mem[rd_ptr];
	assign do_push = port.push_valid && port.push_ready;
	assign do_pop = port.pop_valid && port.pop_ready;

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr] <= port.push_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= ptr_inc(wr_ptr);
			end
			if (do_pop) begin
				rd_ptr <= ptr_inc(rd_ptr);
			end
			if (do_push && !do_pop) begin
				count <= count + 1'b1;
			end else if (do_pop && !do_push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule : hbdp_fifo

/* File: hbdp_fifo_if.sv */
// Stream carrier between the port logic and its transmit FIFO
`timescale 1ns/10ps
interface hbdp_fifo_if;
	import hbdp_pkg::*;
	logic push_valid;
	logic push_ready;
	hbdp_data_t push_data;
	logic pop_valid;
	logic pop_ready;
	hbdp_data_t pop_data;
	modport fifo (
		input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data
	);
	modport user (
		output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data
	);
endinterface : hbdp_fifo_if

/* File: hbdp_host_model.sv */
// Behavioural host processor and DMA master on the bus pins
`timescale 1ns/10ps
module hbdp_host_model (
	input wire logic sys_clk, // Clock
	input wire logic single, // Style set at reset
	input wire logic mux, // Multiplexed bus
	input wire hbdp_pkg::hbdp_data_t ad_out, // Port data
	input wire logic ad_oe, // Port drives
	output logic chip_sel_n, // Select
	output logic addr_latch, // Latch
	output hbdp_pkg::hbdp_addr_t addr_in, // Address
	output logic read_strobe_n, // Read
	output logic write_strobe_n, // Write
	output logic data_strobe_n, // Strobe
	output logic read_not_write, // Direction
	output logic dma_grant_n, // Grant
	output hbdp_pkg::hbdp_data_t ad_in // Bus in
);
	import hbdp_pkg::*;
	initial begin
		chip_sel_n = 1'b1;
		addr_latch = 1'b1;
		addr_in = 8'h00;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		data_strobe_n = 1'b1;
		read_not_write = 1'b1;
		dma_grant_n = 1'b1;
		ad_in = 8'h00;
	end
	// Strobes stand five cycles; select and data are held one more
	task automatic cyc(input logic dma, input logic rd, input hbdp_addr_t a,
		input hbdp_data_t d, output hbdp_data_t q);
		@(negedge sys_clk);
		dma_grant_n <= !dma;
		chip_sel_n <= dma;
		addr_in <= mux ? ~a : a;
		read_not_write <= rd;
		ad_in <= mux ? a : d;
		addr_latch <= 1'b1;
		if (mux) begin
			@(negedge sys_clk);
			addr_latch <= 1'b0;
			ad_in <= d;
		end
		@(negedge sys_clk);
		data_strobe_n <= !single;
		read_strobe_n <= single || !rd;
		write_strobe_n <= single || rd;
		// Read data is taken two and a half periods after the rising edge that set it
		repeat (5) @(negedge sys_clk);
		q = ad_oe ? ad_out : 8'hxx;
		data_strobe_n <= 1'b1;
		read_strobe_n <= 1'b1;
		write_strobe_n <= 1'b1;
		@(negedge sys_clk);
		dma_grant_n <= 1'b1;
		chip_sel_n <= 1'b1;
		ad_in <= ~d;
		addr_latch <= !mux;
		repeat (5) @(negedge sys_clk);
	endtask : cyc
endmodule : hbdp_host_model

/* File: hbdp_pkg.sv */
// Shared constants and types for the host bus and DMA port
package hbdp_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h01;
	localparam logic [ADDR_W-1:0] REG_TX_DATA = 8'h02;
	localparam logic [ADDR_W-1:0] REG_RX_DATA = 8'h03;
	localparam int CTRL_FLYBY_BIT = 0;
	localparam int STAT_TX_FULL_BIT = 0;
	localparam int STAT_RX_FULL_BIT = 1;
	localparam logic CTRL_FLYBY_RESET = 1'b0;
	localparam logic STYLE_SINGLE = 1'b1;
	localparam logic STYLE_RESET = 1'b0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;

	typedef logic [DATA_W-1:0] hbdp_data_t;
	typedef logic [ADDR_W-1:0] hbdp_addr_t;

	typedef enum logic [1:0] {
		HBDP_IDLE = 2'b00,
		HBDP_ACTIVE = 2'b01,
		HBDP_DONE = 2'b11
	} hbdp_state_t;
endpackage : hbdp_pkg

/* File: hbdp_port.sv */
// Host bus and DMA port: strobe decoding, mailboxes and DMA requests
// How it works
// - Separate style: read/write strobes time and direct DMA
// - Normal DMA: write strobe writes, read strobe reads
// - Fly-by DMA inverts strobe meaning for both directions
// - Requests updated on falling edge of DMA strobe
// - DMA read drives bus, floats after strobe rise
// - Separate-style normal DMA write captured on write strobe rise
// - Style pin latched at reset release, high single-strobe
// - Single-strobe style uses separate address bus only
// - Address latch strobe use picks multiplexed or separate
// - Single style: direction line, data strobe times access
// - Qualified strobe active when data strobe, select low
// - Single-strobe register write captured at qualified rise
// - Single-strobe register read drives, floats after rise
// - DMA grant alone marks DMA, selects DMA mailbox
// - Control register bit picks normal or fly-by DMA
`timescale 1ns/10ps
module hbdp_port (
	input wire logic sys_clk, // 50 MHz system clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic style_sel, // Bus style pin, high single-strobe
	input wire logic chip_sel_n, // Chip select, active low
	input wire logic addr_latch, // Address latch strobe
	input wire hbdp_pkg::hbdp_addr_t addr_in, // Separate address bus
	input wire logic read_strobe_n, // Read strobe, separate style
	input wire logic write_strobe_n, // Write strobe, separate style
	input wire logic data_strobe_n, // Data strobe, single style
	input wire logic read_not_write, // Direction, single style
	input wire logic dma_grant_n, // DMA acknowledge, active low
	input wire hbdp_pkg::hbdp_data_t ad_in, // Data or address/data in
	output hbdp_pkg::hbdp_data_t ad_out, // Data bus out
	output logic ad_oe, // Data bus drive enable
	output logic dma_tx_request, // Transmit mailbox wants data
	output logic dma_rx_request, // Receive mailbox holds data
	output hbdp_pkg::hbdp_data_t tx_data, // Transmit stream data
	output logic tx_valid, // Transmit stream valid
	input wire logic tx_ready, // Transmit stream ready
	input wire hbdp_pkg::hbdp_data_t rx_data, // Receive stream data
	input wire logic rx_valid, // Receive stream valid
	output logic rx_ready, // Receive stream ready
	output logic flyby_mode, // Current DMA mode, high fly-by
	output logic single_style // Latched bus style
);
	import hbdp_pkg::*;

	// Transmit words queue here so a DMA burst can run ahead of the sink
	hbdp_fifo_if tx_if ();

	hbdp_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk(sys_clk),
		.rst(rst),
		.port(tx_if.fifo)
	);

	assign tx_data = tx_if.pop_data;
	assign tx_valid = tx_if.pop_valid;
	assign tx_if.pop_ready = tx_ready;

	// Control pins, two flip-flops each; stage one feeds stage two only
	logic [6:0] ctl_s1;
	logic [6:0] ctl_s2;
	hbdp_data_t ad_s1;
	hbdp_data_t ad_s2;
	hbdp_addr_t addr_s1;
	hbdp_addr_t addr_s2;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctl_s1 <= 7'h7f;
			ctl_s2 <= 7'h7f;
		end else begin
			ctl_s1 <= {chip_sel_n, addr_latch, read_strobe_n,
				write_strobe_n, data_strobe_n, read_not_write,
				dma_grant_n};
			ctl_s2 <= ctl_s1;
		end
	end

	// Bus contents are delayed alongside the strobes so they stay aligned
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ad_s1 <= DATA_ZERO;
			ad_s2 <= DATA_ZERO;
			addr_s1 <= ADDR_ZERO;
			addr_s2 <= ADDR_ZERO;
		end else begin
			ad_s1 <= ad_in;
			ad_s2 <= ad_s1;
			addr_s1 <= addr_in;
			addr_s2 <= addr_s1;
		end
	end

	logic cs_s;
	logic ale_s;
	logic rd_s;
	logic wr_s;
	logic ds_s;
	logic rnw_s;
	logic grant_s;
	assign {cs_s, ale_s, rd_s, wr_s, ds_s, rnw_s, grant_s} = ctl_s2;

	// Bus style caught at each release of reset and held until the next reset
	logic rst_seen;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rst_seen <= 1'b1;
		end else begin
			rst_seen <= 1'b0;
		end
	end

	// A later reset samples the pin again, as the first one did
	always_ff @(posedge sys_clk) begin
		if (rst_seen && !rst) begin
			single_style <= style_sel;
		end else if (rst) begin
			single_style <= STYLE_RESET;
		end
	end

	// Strobe either timed by chip select or by the DMA grant alone
	logic sel_any;
	logic qualified_strobe_n;
	logic grant_strobe_n;
	logic access_on;
	assign sel_any = !cs_s || !grant_s;
	assign qualified_strobe_n = ds_s || cs_s;
	// A DMA cycle has no select, so the grant qualifies its strobe
	assign grant_strobe_n = ds_s || grant_s;

	always_comb begin
		if (single_style == STYLE_SINGLE) begin
			access_on = !qualified_strobe_n || !grant_strobe_n;
		end else begin
			access_on = (!rd_s || !wr_s) && sel_any;
		end
	end

	// Direction of an access, inverted for fly-by DMA
	function automatic logic access_is_write(
		input logic style, input logic dma, input logic flyby,
		input logic rd_n, input logic wr_n, input logic rnw
	);
		logic plain_wr;
		// Both strobes low at once falls to the read side
		plain_wr = (style == STYLE_SINGLE) ? !rnw : (!wr_n && rd_n);
		if (dma && flyby) begin
			access_is_write = !plain_wr;
		end else begin
			access_is_write = plain_wr;
		end
	endfunction : access_is_write

	// Multiplexed address taken from the AD bus while the latch is high
	hbdp_addr_t mux_addr;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mux_addr <= ADDR_ZERO;
		end else if (ale_s) begin
			mux_addr <= ADDR_W'(ad_s2);
		end
	end

	hbdp_state_t state;
	logic acc_dma;
	logic acc_write;
	hbdp_addr_t acc_addr;
	hbdp_data_t wr_hold;
	logic start;
	logic finish;
	logic start_write;
	hbdp_addr_t start_addr;
	hbdp_data_t rx_hold;
	logic rx_full;
	logic rx_pop;
	logic push_pulse;
	hbdp_data_t push_word;

	// Direction and address are taken once, at the start edge
	assign start = (state == HBDP_IDLE) && access_on;
	assign finish = (state == HBDP_ACTIVE) && !access_on;
	assign start_write = access_is_write(single_style, !grant_s,
		flyby_mode, rd_s, wr_s, rnw_s);
	// Latch low means a multiplexed cycle has already placed the address
	assign start_addr = (single_style == STYLE_SINGLE || ale_s) ?
		addr_s2 : mux_addr;

	// DONE holds off a new start for one cycle after the strobe rose
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= HBDP_IDLE;
		end else begin
			case (state)
			HBDP_IDLE: begin
				if (access_on) begin
					state <= HBDP_ACTIVE;
				end
			end
			HBDP_ACTIVE: begin
				if (!access_on) begin
					state <= HBDP_DONE;
				end
			end
			HBDP_DONE: begin
				state <= HBDP_IDLE;
			end
			default: begin
				state <= HBDP_IDLE;
			end
			endcase
		end
	end

	// Access attributes frozen at the falling edge of the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc_dma <= 1'b0;
			acc_write <= 1'b0;
			acc_addr <= ADDR_ZERO;
		end else if (start) begin
			acc_dma <= !grant_s;
			acc_write <= start_write;
			acc_addr <= start_addr;
		end
	end

	// Data kept from the last cycle before the strobe rose
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_hold <= DATA_ZERO;
		end else if (start || (state == HBDP_ACTIVE && access_on)) begin
			wr_hold <= ad_s2;
		end
	end

	// Control register written through the host port
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flyby_mode <= CTRL_FLYBY_RESET;
		end else if (finish && acc_write && !acc_dma &&
			acc_addr == REG_CTRL) begin
			flyby_mode <= wr_hold[CTRL_FLYBY_BIT];
		end
	end

	// Writes to the transmit mailbox go into the FIFO at strobe rise
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			push_pulse <= 1'b0;
			push_word <= DATA_ZERO;
		end else begin
			push_pulse <= finish && acc_write &&
				(acc_dma || acc_addr == REG_TX_DATA);
			if (finish) begin
				push_word <= wr_hold;
			end
		end
	end

	// A full FIFO drops the word; the request already warned the master
	assign tx_if.push_valid = push_pulse;
	assign tx_if.push_data = push_word;

	// Receive mailbox: one word held for the host or DMA master
	assign rx_pop = finish && !acc_write &&
		(acc_dma || acc_addr == REG_RX_DATA);
	assign rx_ready = !rx_full;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_full <= 1'b0;
			rx_hold <= DATA_ZERO;
		end else if (rx_valid && !rx_full) begin
			rx_full <= 1'b1;
			rx_hold <= rx_data;
		end else if (rx_pop) begin
			rx_full <= 1'b0;
		end
	end

	function automatic hbdp_data_t read_value(
		input logic dma, input hbdp_addr_t a, input logic flyby,
		input logic rxf, input logic txf, input hbdp_data_t rxd
	);
		hbdp_data_t v;
		v = DATA_ZERO;
		if (dma) begin
			v = rxd;
		end else begin
			case (a)
			REG_CTRL: v[CTRL_FLYBY_BIT] = flyby;
			REG_STATUS: begin
				v[STAT_TX_FULL_BIT] = txf;
				v[STAT_RX_FULL_BIT] = rxf;
			end
			REG_RX_DATA: v = rxd;
			default: v = DATA_ZERO;
			endcase
		end
		read_value = v;
	endfunction : read_value

	// Read data driven from the strobe fall until it rises
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ad_out <= DATA_ZERO;
			ad_oe <= 1'b0;
		end else if (start && !start_write) begin
			ad_out <= read_value(!grant_s, start_addr, flyby_mode,
				rx_full, !tx_if.push_ready, rx_hold);
			ad_oe <= 1'b1;
		end else if (finish || state == HBDP_IDLE) begin
			ad_oe <= 1'b0;
		end
	end

	// Serviced request drops at the strobe fall, others follow status
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dma_tx_request <= 1'b0;
			dma_rx_request <= 1'b0;
		end else if (start && !grant_s) begin
			if (start_write) begin
				dma_tx_request <= 1'b0;
			end else begin
				dma_rx_request <= 1'b0;
			end
		end else if (state == HBDP_IDLE) begin
			// Status is followed only when idle, so a drop stays low
			dma_tx_request <= tx_if.push_ready;
			dma_rx_request <= rx_full;
		end
	end
endmodule : hbdp_port

/* File: hbdp_port_sva.sv */
// Checker on the pins of the host bus and DMA port
`timescale 1ns/10ps
module hbdp_port_sva (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic style_sel, // Style pin
	input wire logic chip_sel_n, // Select
	input wire logic read_strobe_n, // Read
	input wire logic write_strobe_n, // Write
	input wire logic data_strobe_n, // Strobe
	input wire logic dma_grant_n, // Grant
	input wire logic ad_oe, // Drive
	input wire logic dma_tx_request, // Tx
	input wire logic dma_rx_request, // Rx
	input wire logic flyby_mode, // Mode
	input wire logic single_style // Style
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic any_lo;
	logic all_hi;
	logic sel_lo;
	assign all_hi = read_strobe_n && write_strobe_n && data_strobe_n;
	assign sel_lo = !chip_sel_n || !dma_grant_n;
	assign any_lo = !all_hi && sel_lo;
	property p_rst_quiet;
		$past(rst) |-> !ad_oe && !dma_tx_request && !dma_rx_request;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("output active after reset");
	// The load at reset release is seen one edge later
	property p_style_hold;
		!$past(rst) && !$past(rst, 2) |-> $stable(single_style);
	endproperty
	a_style_hold: assert property (p_style_hold)
		else $error("style changed outside reset release");
	property p_style_load;
		$past(rst) |=> single_style == $past(style_sel);
	endproperty
	a_style_load: assert property (p_style_load)
		else $error("style not taken at reset release");
	// Six quiet cycles leave room for the two-stage synchroniser
	property p_oe_release;
		all_hi [*6] |-> !ad_oe;
	endproperty
	a_oe_release: assert property (p_oe_release)
		else $error("bus still driven after strobe rise");
	property p_tx_req_fall;
		$fell(dma_tx_request) |-> $past(any_lo, 2);
	endproperty
	a_tx_req_fall: assert property (p_tx_req_fall)
		else $error("tx request dropped without strobe");
	property p_rd_normal;
		$rose(ad_oe) && !flyby_mode && !single_style
			|-> !$past(read_strobe_n, 2);
	endproperty
	a_rd_normal: assert property (p_rd_normal)
		else $error("normal read without read strobe");
	property p_rd_flyby;
		$rose(ad_oe) && flyby_mode && !single_style && !dma_grant_n
			|-> !$past(write_strobe_n, 2) && $past(read_strobe_n, 2);
	endproperty
	a_rd_flyby: assert property (p_rd_flyby)
		else $error("fly-by read without write strobe");
	property p_single_gate;
		$rose(ad_oe) && single_style
			|-> !$past(data_strobe_n, 2) && $past(sel_lo, 2);
	endproperty
	a_single_gate: assert property (p_single_gate)
		else $error("single read without qualified strobe");
	c_flyby_read: cover property ($rose(ad_oe) && flyby_mode);
	c_single_read: cover property ($rose(ad_oe) && single_style);
	c_tx_drop: cover property ($fell(dma_tx_request));
endmodule : hbdp_port_sva

/* File: test_host_bus_dma_port.sv */
// Self-checking bench for the host bus and DMA port
`timescale 1ns/10ps
module test_host_bus_dma_port;
	import hbdp_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic style_sel = 1'b0;
	logic single = 1'b0;
	logic mux = 1'b0;
	logic tx_ready = 1'b0;
	logic rx_valid = 1'b0;
	hbdp_data_t rx_data = 8'h00;
	logic chip_sel_n, addr_latch, read_strobe_n, write_strobe_n;
	logic data_strobe_n, read_not_write, dma_grant_n, ad_oe, tx_valid;
	logic dma_tx_request, dma_rx_request, rx_ready, flyby_mode, single_style;
	hbdp_addr_t addr_in;
	hbdp_data_t ad_in, ad_out, tx_data, q;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	hbdp_port uut (.*);
	hbdp_host_model host (.*);
	always #10 sys_clk = ~sys_clk;
	task automatic chk(input string n, input hbdp_data_t e, input hbdp_data_t g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic bit_chk(input string n, input logic e, input logic g);
		chk(n, {7'h00, e}, {7'h00, g});
	endtask : bit_chk
	task automatic do_reset(input logic s);
		@(negedge sys_clk);
		rst <= 1'b1;
		style_sel <= s;
		single <= s;
		repeat (8) @(negedge sys_clk);
		bit_chk("oe in reset", 1'b0, ad_oe);
		bit_chk("fly-by in reset", 1'b0, flyby_mode);
		rst <= 1'b0;
		@(negedge sys_clk);
		style_sel <= !s;
		repeat (3) @(negedge sys_clk);
		bit_chk("style", s, single_style);
		bit_chk("tx request", 1'b1, dma_tx_request);
		bit_chk("rx request", 1'b0, dma_rx_request);
	endtask : do_reset
	task automatic pop(input hbdp_data_t e);
		bit_chk("tx valid", 1'b1, tx_valid);
		chk("tx data", e, tx_data);
		tx_ready <= 1'b1;
		@(negedge sys_clk);
		tx_ready <= 1'b0;
		@(negedge sys_clk);
	endtask : pop
	task automatic push_rx(input hbdp_data_t d);
		rx_data <= d;
		rx_valid <= 1'b1;
		@(negedge sys_clk);
		rx_valid <= 1'b0;
		rx_data <= ~d;
		repeat (3) @(negedge sys_clk);
		bit_chk("rx request", 1'b1, dma_rx_request);
		bit_chk("rx ready", 1'b0, rx_ready);
	endtask : push_rx
	task automatic t_normal;
		host.cyc(1'b1, 1'b0, REG_CTRL, 8'ha5, q);
		host.cyc(1'b1, 1'b0, REG_CTRL, 8'h3c, q);
		bit_chk("fly-by", 1'b0, flyby_mode);
		pop(8'ha5);
		pop(8'h3c);
		push_rx(8'hc3);
		host.cyc(1'b1, 1'b1, REG_CTRL, 8'h00, q);
		chk("dma read", 8'hc3, q);
		bit_chk("oe after read", 1'b0, ad_oe);
		bit_chk("rx ready", 1'b1, rx_ready);
		bit_chk("rx request", 1'b0, dma_rx_request);
		$display("normal dma test finished");
	endtask : t_normal
	task automatic t_flyby;
		host.cyc(1'b0, 1'b0, REG_CTRL, 8'h01, q);
		bit_chk("fly-by", 1'b1, flyby_mode);
		host.cyc(1'b1, 1'b1, REG_CTRL, 8'h96, q);
		pop(8'h96);
		push_rx(8'h7e);
		host.cyc(1'b1, 1'b0, REG_CTRL, 8'h00, q);
		chk("fly-by read", 8'h7e, q);
		$display("fly-by dma test finished");
	endtask : t_flyby
	task automatic t_mux;
		mux <= 1'b1;
		host.cyc(1'b0, 1'b1, REG_CTRL, 8'h00, q);
		chk("mux read", 8'h01, q);
		host.cyc(1'b0, 1'b1, 8'h10, 8'h00, q);
		chk("unmapped read", 8'h00, q);
		host.cyc(1'b0, 1'b0, REG_CTRL, 8'h00, q);
		bit_chk("fly-by", 1'b0, flyby_mode);
		mux <= 1'b0;
		$display("multiplexed bus test finished");
	endtask : t_mux
	// Overfills by one word while the sink stalls
	task automatic t_fill;
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			host.cyc(1'b1, 1'b0, REG_CTRL, 8'(i), q);
		end
		bit_chk("tx request full", 1'b0, dma_tx_request);
		host.cyc(1'b0, 1'b1, REG_STATUS, 8'h00, q);
		chk("status", 8'h01, q);
		host.cyc(1'b1, 1'b0, REG_CTRL, 8'hee, q);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			pop(8'(i));
		end
		bit_chk("tx empty", 1'b0, tx_valid);
		repeat (3) @(negedge sys_clk);
		bit_chk("tx request", 1'b1, dma_tx_request);
		$display("fifo fill test finished");
	endtask : t_fill
	task automatic t_single;
		do_reset(1'b1);
		host.cyc(1'b0, 1'b0, REG_CTRL, 8'h01, q);
		bit_chk("fly-by", 1'b1, flyby_mode);
		host.cyc(1'b0, 1'b1, REG_CTRL, 8'h00, q);
		chk("single read", 8'h01, q);
		push_rx(8'h5a);
		host.cyc(1'b1, 1'b0, REG_CTRL, 8'h00, q);
		chk("single fly-by read", 8'h5a, q);
		host.cyc(1'b0, 1'b0, REG_TX_DATA, 8'h2d, q);
		pop(8'h2d);
		push_rx(8'hb4);
		host.cyc(1'b0, 1'b1, REG_RX_DATA, 8'h00, q);
		chk("mailbox read", 8'hb4, q);
		bit_chk("rx request", 1'b0, dma_rx_request);
		// A strobe with neither select nor grant must be ignored
		host.read_not_write <= 1'b1;
		host.data_strobe_n <= 1'b0;
		repeat (5) @(negedge sys_clk);
		bit_chk("unselected strobe", 1'b0, ad_oe);
		host.data_strobe_n <= 1'b1;
		repeat (5) @(negedge sys_clk);
		$display("single strobe test finished");
	endtask : t_single
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			tally_and_finish;
		end
	end
	initial begin
		do_reset(1'b0);
		t_normal;
		t_flyby;
		t_mux;
		t_fill;
		t_single;
		tally_and_finish;
	end
endmodule : test_host_bus_dma_port
bind hbdp_port hbdp_port_sva u_sva (
	.sys_clk(sys_clk),
	.rst(rst),
	.style_sel(style_sel),
	.chip_sel_n(chip_sel_n),
	.read_strobe_n(read_strobe_n),
	.write_strobe_n(write_strobe_n),
	.data_strobe_n(data_strobe_n),
	.dma_grant_n(dma_grant_n),
	.ad_oe(ad_oe),
	.dma_tx_request(dma_tx_request),
	.dma_rx_request(dma_rx_request),
	.flyby_mode(flyby_mode),
	.single_style(single_style)
);
